// ===== shared/rm8_map.vh
// Constants and function summary for the registered 8x8 multiplier
// Function
// [RULE1] Form the full 16-bit product of the two captured 8-bit operands.
// [RULE2] Signed variant treats operands and product as two's complement values.
// [RULE3] Signed variant gives two bytes, sign copied into top bit of each.
// [RULE4] Unsigned variant treats operands and product as unsigned magnitudes.
// [RULE5] Operand A, operand B and product registers each load on own clock.
// [RULE6] Product outputs are three-state so they can share a bus.
// [RULE7] Signed variant captures round request on rising edge of A OR B clock.
// [RULE8] Unsigned variant captures round request on operand A clock edge only.
// [RULE9] Captured round adds one at top bit of low product byte; signed variant adds at bit 6 instead (16'h0040).
// [RULE10] Product register loads array result on its clock edge, holds between.
// [RULE11] Each product half has its own active-low output enable.
`ifndef RM8_MAP_VH
`define RM8_MAP_VH
`define RM8_OP_W        8
`define RM8_PROD_W      16
`define RM8_SYNC_W      22
`define RM8_RND_SIGNED  16'h0040
`define RM8_RND_UNSIGN  16'h0080
`define RM8_OP_RST      8'h00
`define RM8_PROD_RST    16'h0000
`endif

// ===== verilog/rm8_mult.v
// Registered 8x8 multiplier with independently clocked registers
`timescale 1ns/1ps
`include "rm8_map.vh"
module rm8_mult #(
    parameter SIGNED_MODE = 1                       // 1 signed variant, 0 unsigned
) (
    input  wire        clk_sys,                     // System clock, 50 MHz
    input  wire        rst_b,                       // Synchronous reset, active low
    input  wire        ce,                          // Clock enable, freezes state
    input  wire [7:0]  a_in,                        // Operand A pins
    input  wire [7:0]  b_in,                        // Operand B pins
    input  wire        round_request,               // Round request pin
    input  wire        clk_a_in,                    // Operand A load clock pin
    input  wire        clk_b_in,                    // Operand B load clock pin
    input  wire        clk_r_in,                    // Product load clock pin
    input  wire        oe_hi_b,                     // Upper half enable, active low
    input  wire        oe_lo_b,                     // Lower half enable, active low
    output wire [7:0]  prod_hi_out,                 // Upper product byte
    output wire        prod_hi_oe,                  // Upper byte drive enable
    output wire [7:0]  prod_lo_out,                 // Lower product byte
    output wire        prod_lo_oe                   // Lower byte drive enable
);

    // Bit positions of each pin inside the synchroniser word
    localparam A_TOP   = 21;                        // Operand A, top bit
    localparam A_BOT   = 14;                        // Operand A, bottom bit
    localparam B_TOP   = 13;                        // Operand B, top bit
    localparam B_BOT   = 6;                         // Operand B, bottom bit
    localparam RND_BIT = 5;                         // Round request pin
    localparam CA_BIT  = 4;                         // Operand A load clock
    localparam CB_BIT  = 3;                         // Operand B load clock
    localparam CR_BIT  = 2;                         // Product load clock
    localparam OEH_BIT = 1;                         // Upper enable, active low
    localparam OEL_BIT = 0;                         // Lower enable, active low

    // Rising edge of a synchronised level against its previous sample
    function rm8_rise;
        input cur;                                  // Level this cycle
        input prev;                                 // Level one cycle earlier
        begin
            rm8_rise = cur & ~prev;
        end
    endfunction

    // Synchroniser stages
    reg  [`RM8_SYNC_W-1:0] sync1_reg;               // First stage, every pin
    reg  [`RM8_SYNC_W-1:2] sync2_reg;               // Second stage, data and clocks
    reg                    oe_hi_reg;               // Second stage, upper drive enable
    reg                    oe_lo_reg;               // Second stage, lower drive enable

    // Load clock history for edge detection
    reg                    ca_hist_reg;             // Previous A clock level
    reg                    cb_hist_reg;             // Previous B clock level
    reg                    cr_hist_reg;             // Previous product clock level

    // Operand, round and product registers
    reg  [`RM8_OP_W-1:0]   a_reg;                   // Operand A register
    reg  [`RM8_OP_W-1:0]   b_reg;                   // Operand B register
    reg                    rnd_reg;                 // Captured round request
    reg  [`RM8_PROD_W-1:0] prod_reg;                // Product register
    reg  [`RM8_PROD_W-1:0] prod_next;               // Array result with round
    reg  [`RM8_PROD_W-1:0] fmt_next;                // Formatted product for loading

    // Pin word and its synchronised fields
    wire [`RM8_SYNC_W-1:0] pin_word;                // All pins, sampled together
    wire [`RM8_OP_W-1:0]   a_s;                     // Synchronised operand A
    wire [`RM8_OP_W-1:0]   b_s;                     // Synchronised operand B
    wire                   rnd_s;                   // Synchronised round request
    wire                   ca_s;                    // Synchronised A clock
    wire                   cb_s;                    // Synchronised B clock
    wire                   cr_s;                    // Synchronised product clock

    // Detected load events
    wire                   a_edge;                  // A clock rose
    wire                   b_edge;                  // B clock rose
    wire                   r_edge;                  // Product clock rose
    wire                   or_edge;                 // A OR B clock rose
    wire                   rnd_edge;                // Round capture event

    // Gather pins so data and clocks share one synchroniser delay
    assign pin_word = {a_in, b_in, round_request, clk_a_in, clk_b_in, clk_r_in,
                       oe_hi_b, oe_lo_b};

    // Split the second stage into named fields
    assign a_s   = sync2_reg[A_TOP:A_BOT];
    assign b_s   = sync2_reg[B_TOP:B_BOT];
    assign rnd_s = sync2_reg[RND_BIT];
    assign ca_s  = sync2_reg[CA_BIT];
    assign cb_s  = sync2_reg[CB_BIT];
    assign cr_s  = sync2_reg[CR_BIT];

    // Rising edges of the synchronised load clocks
    assign a_edge   = rm8_rise(ca_s, ca_hist_reg);  // [RULE5]
    assign b_edge   = rm8_rise(cb_s, cb_hist_reg);  // [RULE5]
    assign r_edge   = rm8_rise(cr_s, cr_hist_reg);  // [RULE10]
    assign or_edge  = rm8_rise(ca_s | cb_s, ca_hist_reg | cb_hist_reg); // [RULE7]

    // Round follows A OR B when signed, A alone when unsigned
    assign rnd_edge = (SIGNED_MODE != 0) ? or_edge : a_edge; // [RULE7] [RULE8]

    // Multiply array with rounding
    always @* begin
        prod_next = {`RM8_PROD_W{1'b0}};
        if (SIGNED_MODE != 0) begin
            prod_next = $signed(a_reg) * $signed(b_reg); // [RULE1] [RULE2]
            if (rnd_reg)
                prod_next = prod_next + `RM8_RND_SIGNED;  // [RULE9]
        end else begin
            prod_next = a_reg * b_reg;                    // [RULE1] [RULE4]
            if (rnd_reg)
                prod_next = prod_next + `RM8_RND_UNSIGN;  // [RULE9]
        end
    end

    // Signed: sign heads both bytes, redundant bit 14 dropped
    always @* begin
        fmt_next = prod_next;
        if (SIGNED_MODE != 0)
            fmt_next = {prod_next[15], prod_next[13:7],
                        prod_next[15], prod_next[6:0]};   // [RULE3]
    end

    // First synchroniser stage, the only reader of the pins
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            sync1_reg <= {`RM8_SYNC_W{1'b0}};
        end else if (ce) begin
            sync1_reg <= pin_word;
        end
    end

    // Second synchroniser stage for data and load clocks
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            sync2_reg <= {(`RM8_SYNC_W-2){1'b0}};
        end else if (ce) begin
            sync2_reg <= sync1_reg[`RM8_SYNC_W-1:2];
        end
    end

    // Second stage for the enables, stored already inverted
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            oe_hi_reg <= 1'b1;
            oe_lo_reg <= 1'b1;
        end else if (ce) begin
            oe_hi_reg <= ~sync1_reg[OEH_BIT];             // [RULE11]
            oe_lo_reg <= ~sync1_reg[OEL_BIT];             // [RULE11]
        end
    end

    // Load clock history, one cycle behind the second stage
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            ca_hist_reg <= 1'b0;
            cb_hist_reg <= 1'b0;
            cr_hist_reg <= 1'b0;
        end else if (ce) begin
            ca_hist_reg <= ca_s;
            cb_hist_reg <= cb_s;
            cr_hist_reg <= cr_s;
        end
    end

    // Operand A register on its own load clock
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            a_reg <= `RM8_OP_RST;
        end else if (ce) begin
            if (a_edge)
                a_reg <= a_s;                             // [RULE5]
        end
    end

    // Operand B register on its own load clock
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            b_reg <= `RM8_OP_RST;
        end else if (ce) begin
            if (b_edge)
                b_reg <= b_s;                             // [RULE5]
        end
    end

    // Round request, captured on the variant's round event
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            rnd_reg <= 1'b0;
        end else if (ce) begin
            if (rnd_edge)
                rnd_reg <= rnd_s;                         // [RULE7] [RULE8]
        end
    end

    // Product register, holds between product clock edges
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            prod_reg <= `RM8_PROD_RST;
        end else if (ce) begin
            if (r_edge)
                prod_reg <= fmt_next;                     // [RULE5] [RULE10]
        end
    end

    // Byte outputs straight from the product register
    assign prod_hi_out = prod_reg[15:8];
    assign prod_lo_out = prod_reg[7:0];

    // Drive enables from flops; a low enable floats that half
    assign prod_hi_oe  = oe_hi_reg;                       // [RULE6] [RULE11]
    assign prod_lo_oe  = oe_lo_reg;                       // [RULE6] [RULE11]

endmodule // rm8_mult

// ===== bench/rm8_src.sv
// Operand source model driving the multiplier pins
`timescale 1ns/1ps
module rm8_src(input wire clk_sys, output reg [7:0] a_in = 8'h00, b_in = 8'h00,
    output reg round_request = 1'b0, clk_a_in = 1'b0, clk_b_in = 1'b0, clk_r_in = 1'b0);
    // Load one operand on its own clock, s high selects B
    task automatic ld(input bit s, input [7:0] v, input bit r);
        @(negedge clk_sys) if (s) b_in = v; else a_in = v;
        round_request = r;
        repeat (2) @(negedge clk_sys) if (s) clk_b_in = 1; else clk_a_in = 1;
        repeat (2) @(negedge clk_sys) {clk_a_in, clk_b_in} = 2'h0;
        repeat (2) @(negedge clk_sys) round_request = ~r; // Junk once hold is over
        if (s) b_in = ~v; else a_in = ~v;
    endtask
    // Product clock pulse, two cycles high
    task automatic pr;
        repeat (2) @(negedge clk_sys) clk_r_in = 1;
        repeat (2) @(negedge clk_sys) clk_r_in = 0;
    endtask
endmodule // rm8_src

// ===== bench/rm8_mult_asserts.sv
// Output checker for the registered multiplier
`timescale 1ns/1ps
module rm8_mult_asserts #(parameter SIGNED_MODE = 1) (input wire clk_sys, rst_b, clk_r_in,
    oe_hi_b, oe_lo_b, prod_hi_oe, prod_lo_oe, input wire [7:0] prod_hi_out, prod_lo_out);
    reg [2:0] up_reg = 3'h0;
    reg [3:0] cr_reg = 4'h0;
    // Reset and product clock history
    always @(posedge clk_sys) begin
        up_reg <= {up_reg[1:0], rst_b};
        cr_reg <= {cr_reg[2:0], clk_r_in};
    end
    wire up = &up_reg;
    wire ld = (cr_reg[2] & ~cr_reg[3]) | (cr_reg[1] & ~cr_reg[2]);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    a_reset_zero: assert property (disable iff (1'b0) !rst_b |=>
        {prod_hi_out, prod_lo_out} == 16'h0000) else $error("reset value");
    a_oe_reset: assert property (disable iff (1'b0) !rst_b |=>
        prod_hi_oe && prod_lo_oe) else $error("reset enable");
    a_hi_hold: assert property (up && !ld |-> $stable(prod_hi_out)) else $error("hi");
    a_lo_hold: assert property (up && !ld |-> $stable(prod_lo_out)) else $error("lo");
    a_hi_settle: assert property ($changed(prod_hi_out) |=> $stable(prod_hi_out)[*3])
        else $error("hi twice");
    a_sign_copy: assert property (SIGNED_MODE == 0 || prod_hi_out[7] == prod_lo_out[7])
        else $error("sign copy");
    a_hi_drive: assert property (up |-> prod_hi_oe == !$past(oe_hi_b, 2)) else $error("hi oe");
    a_lo_drive: assert property (up |-> prod_lo_oe == !$past(oe_lo_b, 2)) else $error("lo oe");
    cover property ($changed(prod_lo_out) && prod_lo_oe);
    cover property (!prod_hi_oe);
    cover property (prod_hi_out[7]);
endmodule // rm8_mult_asserts

// ===== bench/rm8_mult_tb_top.sv
// Self-checking bench for the registered multiplier
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; $display("Error t=%0t got %h exp %h", $time, g, e); end end
module rm8_mult_tb_top;
    reg clk_sys = 0, rst_b = 0, ce = 1, oe_hi_b = 0, oe_lo_b = 0;
    wire [7:0] a_in, b_in, prod_hi_out, prod_lo_out, u_hi_out, u_lo_out;
    wire round_request, clk_a_in, clk_b_in, clk_r_in, prod_hi_oe, prod_lo_oe, u_hi_oe, u_lo_oe;
    wire [7:0] bh = prod_hi_oe ? prod_hi_out : 8'hzz; // Shared bus wires
    wire [7:0] bl = prod_lo_oe ? prod_lo_out : 8'hzz;
    wire [7:0] uh = u_hi_oe ? u_hi_out : 8'hzz; // Unsigned variant bus wires
    wire [7:0] ul = u_lo_oe ? u_lo_out : 8'hzz;
    // Bit 17 rounds on A, bit 16 rounds on B
    int errors = 0, n_compared = 0, eq[$] = '{'h28080, 'h18080, 'h17f7f, 'h27f80, 'h1ff01, 'h0, 'h3ffff};
    logic [15:0] qs = 16'h0000, qu = 16'h0000; // Expected signed and unsigned products
    rm8_mult rm8_mult_i(.*);
    rm8_mult #(.SIGNED_MODE(0)) rm8_mult_u_i(.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce),
        .a_in(a_in), .b_in(b_in), .round_request(round_request), .clk_a_in(clk_a_in),
        .clk_b_in(clk_b_in), .clk_r_in(clk_r_in), .oe_hi_b(oe_hi_b), .oe_lo_b(oe_lo_b),
        .prod_hi_out(u_hi_out), .prod_hi_oe(u_hi_oe), .prod_lo_out(u_lo_out), .prod_lo_oe(u_lo_oe));
    rm8_src rm8_src_i(.*);
    always #10 clk_sys = ~clk_sys;
    task test_done;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Both variants' bus wires against the expected products
    task automatic chk;
        `CHK(bh, (oe_hi_b ? 8'hzz : {qs[15], qs[13:7]}))
        `CHK(bl, (oe_lo_b ? 8'hzz : {qs[15], qs[6:0]}))
        `CHK(uh, (oe_hi_b ? 8'hzz : qu[15:8]))
        `CHK(ul, (oe_lo_b ? 8'hzz : qu[7:0]))
    endtask
    // A carries round ra, B carries rb: signed keeps rb, unsigned keeps ra
    task automatic mul(input [7:0] a, b, input bit ra, rb);
        @(negedge clk_sys) {oe_hi_b, oe_lo_b} = $urandom;
        rm8_src_i.ld(0, a, ra);
        rm8_src_i.ld(1, b, rb);
        rm8_src_i.pr;
        repeat (4) @(negedge clk_sys);
        qs = $signed(a) * $signed(b) + (rb ? 64 : 0);
        qu = a * b + (ra ? 128 : 0);
        chk;
        $display("test %h*%h r%0d%0d done", a, b, ra, rb);
    endtask
    initial begin
        void'($urandom(63192));
        repeat (8) @(negedge clk_sys);
        rst_b = 1;
        foreach (eq[i]) mul(eq[i][15:8], eq[i][7:0], eq[i][17], eq[i][16]);
        repeat (20) mul($urandom, $urandom, $urandom, $urandom);
        mul(8'h05, 8'h07, 0, 0);
        rm8_src_i.ld(0, 8'h03, 0);
        @(negedge clk_sys) ce = 0; // Product pulse while frozen must be lost
        rm8_src_i.pr;
        @(negedge clk_sys) ce = 1;
        repeat (4) @(negedge clk_sys);
        chk;
        $display("test freeze done");
        rm8_src_i.pr;
        repeat (4) @(negedge clk_sys);
        qs = 16'h0015;
        qu = 16'h0015;
        chk;
        $display("test reload done");
        test_done;
    end
    initial begin #60000; errors++; test_done; end
endmodule // rm8_mult_tb_top
bind rm8_mult rm8_mult_asserts #(.SIGNED_MODE(SIGNED_MODE)) rm8_mult_asserts_i(.*);
